// [hw/vectored_irq_pkg.sv]
package vectored_irq_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_TIMER_MODE  = 8'hF1;
    localparam logic [7:0] IDX_TIMER_COUNT = 8'hF4;
    localparam logic [7:0] IDX_PRESCALE    = 8'hF5;
    localparam logic [7:0] IDX_PRIORITY    = 8'hF9;
    localparam logic [7:0] IDX_PENDING     = 8'hFA;
    localparam logic [7:0] IDX_MASK        = 8'hFB;
    localparam logic [7:0] IDX_EVT_STATUS  = 8'hE0;
    localparam logic [7:0] IDX_EVT_MASK    = 8'hE1;
    localparam logic [7:0] IDX_PIN_CONFIG  = 8'hE2;

    // field positions
    localparam int TMR_LOAD_BIT    = 0;
    localparam int TMR_RUN_BIT     = 1;
    localparam int PRE_CONT_BIT    = 0;
    localparam int PRE_VALUE_LSB   = 2;
    localparam int MASK_GLOBAL_BIT = 7;
    localparam int HOT_BIT         = 7;
    localparam int WARM_BIT        = 6;
    localparam int EVT_TIMER       = 0;
    localparam int EVT_STOP_WAKE   = 1;
    localparam int EVT_WATCHDOG    = 2;
    localparam int EVT_GRANT       = 3;

    // sizes and vector layout
    localparam int          NUM_SOURCES   = 5;
    localparam int          NUM_PINS      = 4;
    localparam int          ROW_WIDTH     = 8;
    localparam logic [15:0] VECTOR_BASE   = 16'h0000;
    localparam logic [15:0] VECTOR_STRIDE = 16'h0002;

    // values after reset
    localparam logic [7:0] RST_MASK     = 8'h00;
    localparam logic [2:0] RST_PRIORITY = 3'h0;
    localparam logic [3:0] RST_PIN_CFG  = 4'h0;
    localparam logic [5:0] RST_PRESCALE = 6'h00;
    localparam logic [7:0] RST_COUNT    = 8'h00;
    localparam logic [3:0] RST_EVT      = 4'h0;

    // core side of the vectored request
    typedef struct packed {
        logic        grant;    // one-cycle pulse: core accepts the presented source
        logic        iret;     // one-cycle pulse: service over, unblock interrupts
    } coreIn_t;

    typedef struct packed {
        logic        intReq;   // an enabled request is waiting
        logic [2:0]  source;   // presented source number
        logic [15:0] vector;   // program address of its vector pair
    } coreOut_t;

    // rotating priority: start is the favoured source, then upward
    function automatic logic [2:0] pickSource(input logic [4:0] req, input logic [2:0] start);
        logic [2:0] idx;
        logic [2:0] found;
        logic       hit;
        found = 3'h0;
        hit   = 1'b0;
        for (int i = 0; i < NUM_SOURCES; i++) begin
            idx = 3'((int'(start) + i) % NUM_SOURCES);
            if (!hit && req[idx]) begin
                found = idx;
                hit   = 1'b1;
            end
        end
        return found;
    endfunction : pickSource

    // high-to-low transitions between two samples
    function automatic logic [7:0] fallEdge(input logic [7:0] prev, input logic [7:0] cur);
        return prev & ~cur;
    endfunction : fallEdge

endpackage : vectored_irq_pkg

// [hw/vectored_irq_with_timer.sv]
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none

module vectored_irq_with_timer
    import vectored_irq_pkg::*;
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 sys_rst,
    // avalon-mm slave
    input  wire logic [9:0]           address,
    input  wire logic                 read,
    input  wire logic                 write,
    input  wire logic [31:0]          writedata,
    input  wire logic [3:0]           byteenable,
    output logic      [31:0]          readdata,
    output logic                      waitrequest,
    // external request pins
    input  wire logic [NUM_PINS-1:0]  requestInputPins,
    // processor core
    input  wire coreIn_t              coreIn,
    output coreOut_t                  coreOut,
    // power management
    input  wire logic                 haltMode,
    input  wire logic                 stopMode,
    input  wire logic                 wdtTimeout,
    input  wire logic [ROW_WIDTH-1:0] rowPins,
    input  wire logic                 hostData,
    output logic                      haltWake,
    output logic                      stopWake,
    // event interrupt
    output logic                      irq
);

    // bus state
    logic        waitReq_q;
    logic [31:0] readData_q;
    logic [7:0]  rdVal;
    logic [7:0]  busIdx;
    logic        busReq;
    logic        busDone;
    logic        wrStb;
    logic        rdStb;
    logic        wrMode;

    // timer state
    logic [7:0]  count_q;
    logic [7:0]  initVal_q;
    logic [5:0]  preCount_q;
    logic [5:0]  preSet_q;
    logic        contMode_q;
    logic        run_q;
    logic        preEnd;
    logic        timerTc;
    logic        timerLoad;

    // interrupt state
    logic [4:0]  pending_q;
    logic [4:0]  pending_d;
    logic [7:0]  mask_q;
    logic [2:0]  priority_q;
    logic [3:0]  pinCfg_q;
    logic [3:0]  pinPrev_q;
    logic [4:0]  srcEvents;
    logic [7:0]  pinFall;
    logic [4:0]  enabledReq;
    logic        anyReq;
    logic [2:0]  selSource;
    logic        grantStb;
    coreOut_t    coreOut_q;

    // power state
    logic        hotFlag_q;
    logic        warmFlag_q;
    logic        stopPrev_q;
    logic [7:0]  rowPrev_q;
    logic        hostPrev_q;
    logic        wakeEvt;
    logic        haltWake_q;
    logic        stopWake_q;
    logic        pendRead;
    logic        stopEntry;

    // event status
    logic [3:0]  evtStatus_q;
    logic [3:0]  evtMask_q;
    logic [3:0]  evtSet;
    logic        irq_q;

    // watchdog time-out resets control state but not the bus registers, the hot-start bit, or the event status, mask and irq registers
    logic        softRst;
    assign softRst = sys_rst | wdtTimeout;

    // bus decode; only byte lane 0 carries register data
    assign busIdx  = address[9:2];
    assign busReq  = read | write;
    assign busDone = busReq & ~waitReq_q;
    assign wrStb   = busDone & write & byteenable[0];
    assign rdStb   = busDone & read;
    assign wrMode  = wrStb & (busIdx == IDX_TIMER_MODE);

    // every access takes two cycles: waitrequest drops for one cycle only
    // the master must hold its request through the wait cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            waitReq_q <= 1'b1;
        end else begin
            waitReq_q <= ~(busReq & waitReq_q);
        end
    end

    // read data is captured one edge ahead of completion and held
    // capturing early lets readdata come straight from a flip-flop
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            readData_q <= 32'h0000_0000;
        end else if (busReq && waitReq_q) begin
            readData_q <= {24'h00_0000, (read ? rdVal : 8'h00)};
        end
    end

    // read mux; write-only registers and unmapped indices read zero
    always_comb begin
        case (busIdx)
            IDX_TIMER_MODE:  rdVal = {6'h00, run_q, 1'b0};
            IDX_TIMER_COUNT: rdVal = count_q;
            IDX_PRESCALE:    rdVal = 8'h00;
            IDX_PRIORITY:    rdVal = 8'h00;
            IDX_PENDING:     rdVal = {hotFlag_q, warmFlag_q, 1'b0, pending_q};
            IDX_MASK:        rdVal = mask_q;
            IDX_EVT_STATUS:  rdVal = {4'h0, evtStatus_q};
            IDX_EVT_MASK:    rdVal = {4'h0, evtMask_q};
            IDX_PIN_CONFIG:  rdVal = {4'h0, pinCfg_q};
            default:         rdVal = 8'h00;
        endcase
    end

    // prescaler setting and counter mode; writing the count sets the initial value
    always_ff @(posedge ref_clk) begin
        if (softRst) begin
            preSet_q   <= RST_PRESCALE;
            contMode_q <= 1'b0;
            initVal_q  <= RST_COUNT;
        end else if (wrStb) begin
            if (busIdx == IDX_PRESCALE) begin
                preSet_q   <= writedata[PRE_VALUE_LSB +: 6];
                contMode_q <= writedata[PRE_CONT_BIT];
            end
            if (busIdx == IDX_TIMER_COUNT) begin
                initVal_q <= writedata[7:0];
            end
        end
    end

    // a zero setting means a full wrap, so 0 gives 64 or 256
    assign timerLoad = wrMode && writedata[TMR_LOAD_BIT];
    assign preEnd    = run_q && (preCount_q == 6'h01);
    assign timerTc   = preEnd && (count_q == 8'h01);

    // prescaler and counter; reading never touches them
    always_ff @(posedge ref_clk) begin
        if (softRst) begin
            preCount_q <= RST_PRESCALE;
            count_q    <= RST_COUNT;
        end else if (timerLoad) begin
            preCount_q <= preSet_q;
            count_q    <= initVal_q;
        end else if (run_q) begin
            if (preEnd) begin
                preCount_q <= preSet_q;
                if (count_q == 8'h01) begin
                    count_q <= contMode_q ? initVal_q : 8'h00;
                end else begin
                    count_q <= count_q - 8'h01;
                end
            end else begin
                preCount_q <= preCount_q - 6'h01;
            end
        end
    end

    // run control: start or stop by write, single pass halts itself at zero
    always_ff @(posedge ref_clk) begin
        if (softRst) begin
            run_q <= 1'b0;
        end else if (wrMode) begin
            run_q <= writedata[TMR_RUN_BIT];
        end else if (timerTc && !contMode_q) begin
            run_q <= 1'b0;
        end
    end

    // priority and pin configuration
    always_ff @(posedge ref_clk) begin
        if (softRst) begin
            priority_q <= RST_PRIORITY;
            pinCfg_q   <= RST_PIN_CFG;
        end else if (wrStb) begin
            if (busIdx == IDX_PRIORITY) begin
                priority_q <= writedata[2:0];
            end
            if (busIdx == IDX_PIN_CONFIG) begin
                pinCfg_q <= writedata[3:0];
            end
        end
    end

    // pin sampling for edge detection; pins are taken as synchronous
    // history resets to the pulled-up idle level, so reset makes no false edge
    always_ff @(posedge ref_clk) begin
        if (softRst) begin
            pinPrev_q <= 4'hF;
        end else begin
            pinPrev_q <= requestInputPins;
        end
    end

    // sources: falling edge on a configured pin, or timer end of count
    assign pinFall        = fallEdge({4'h0, pinPrev_q}, {4'h0, requestInputPins});
    assign srcEvents[3:0] = pinFall[3:0] & pinCfg_q;
    assign srcEvents[4]   = timerTc;

    // pending bits latch regardless of mask; new events win over clears
    always_comb begin
        pending_d = pending_q;
        if (wrStb && busIdx == IDX_PENDING) begin
            pending_d = writedata[4:0];
        end
        if (grantStb) begin
            pending_d = pending_d & ~(5'h01 << coreOut_q.source);
        end
        pending_d = pending_d | srcEvents;
    end

    always_ff @(posedge ref_clk) begin
        if (softRst) begin
            pending_q <= 5'h00;
        end else begin
            pending_q <= pending_d;
        end
    end

    // mask: grant drops the global enable, return from service restores it
    assign grantStb = coreIn.grant & coreOut_q.intReq;

    always_ff @(posedge ref_clk) begin
        if (softRst) begin
            mask_q <= RST_MASK;
        end else if (wrStb && busIdx == IDX_MASK) begin
            mask_q <= writedata[7:0];
        end else if (grantStb) begin
            mask_q[MASK_GLOBAL_BIT] <= 1'b0;
        end else if (coreIn.iret) begin
            mask_q[MASK_GLOBAL_BIT] <= 1'b1;
        end
    end

    // selection of the one request to present
    assign enabledReq = pending_q & mask_q[4:0];
    assign anyReq     = mask_q[MASK_GLOBAL_BIT] & (|enabledReq);
    assign selSource  = pickSource(enabledReq, priority_q);

    // presented request is registered, so the core sees a stable pair
    always_ff @(posedge ref_clk) begin
        if (softRst) begin
            coreOut_q <= '0;
        end else begin
            coreOut_q.intReq <= anyReq & ~grantStb;
            coreOut_q.source <= selSource;
            coreOut_q.vector <= VECTOR_BASE + ({13'h0000, selSource} * VECTOR_STRIDE);
        end
    end

    // halt leaves timer and pins running; any enabled request wakes the core
    always_ff @(posedge ref_clk) begin
        if (softRst) begin
            haltWake_q <= 1'b0;
        end else begin
            haltWake_q <= haltMode & (|enabledReq);
        end
    end

    // stop-mode recovery: falling row or host data edge while stopped
    assign wakeEvt = stopMode
                     & ((|fallEdge(rowPrev_q, rowPins)) | (hostPrev_q & ~hostData));

    always_ff @(posedge ref_clk) begin
        if (softRst) begin
            rowPrev_q  <= 8'hFF;
            hostPrev_q <= 1'b1;
            stopPrev_q <= 1'b0;
            stopWake_q <= 1'b0;
        end else begin
            rowPrev_q  <= rowPins;
            hostPrev_q <= hostData;
            stopPrev_q <= stopMode;
            stopWake_q <= wakeEvt;
        end
    end

    // clear-on-read strobe shared by the two status flags, and stop entry for the warm flag
    assign pendRead  = rdStb && (busIdx == IDX_PENDING);
    assign stopEntry = stopMode && !stopPrev_q;

    // hot-start flag survives the watchdog reset it reports; power-up clears it
    // a time-out in the cycle of a read keeps the flag, so no event is lost
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hotFlag_q <= 1'b0;
        end else if (wdtTimeout) begin
            hotFlag_q <= 1'b1;
        end else if (pendRead) begin
            hotFlag_q <= 1'b0;
        end
    end

    // warm flag: set entering stop; a reset wake clears it, a stop-recovery wake keeps it
    // stop entry in the cycle of a read wins in the same way
    always_ff @(posedge ref_clk) begin
        if (softRst) begin
            warmFlag_q <= 1'b0;
        end else if (stopEntry) begin
            warmFlag_q <= 1'b1;
        end else if (pendRead) begin
            warmFlag_q <= 1'b0;
        end
    end

    // sticky event status, write one to clear; a set in the same cycle wins
    assign evtSet[EVT_TIMER]     = timerTc;
    assign evtSet[EVT_STOP_WAKE] = wakeEvt;
    assign evtSet[EVT_WATCHDOG]  = wdtTimeout;
    assign evtSet[EVT_GRANT]     = grantStb;

    // sys_rst only, so a watchdog event stays visible after its own reset
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            evtStatus_q <= RST_EVT;
        end else if (wrStb && busIdx == IDX_EVT_STATUS) begin
            evtStatus_q <= (evtStatus_q & ~writedata[3:0]) | evtSet;
        end else begin
            evtStatus_q <= evtStatus_q | evtSet;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            evtMask_q <= RST_EVT;
        end else if (wrStb && busIdx == IDX_EVT_MASK) begin
            evtMask_q <= writedata[3:0];
        end
    end

    // level interrupt, one cycle behind the status bits
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(evtStatus_q & evtMask_q);
        end
    end

    // outputs straight from flip-flops
    assign readdata    = readData_q;
    assign waitrequest = waitReq_q;
    assign coreOut     = coreOut_q;
    assign haltWake    = haltWake_q;
    assign stopWake    = stopWake_q;
    assign irq         = irq_q;

endmodule : vectored_irq_with_timer

`default_nettype wire

// [testbench/vectored_irq_props.sv]
`timescale 1ns/10ps
`default_nettype none

module vectored_irq_props
    import vectored_irq_pkg::*;
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 sys_rst,
    // register bus
    input  wire logic                 read,
    input  wire logic                 write,
    input  wire logic [31:0]          readdata,
    input  wire logic                 waitrequest,
    // core side
    input  wire coreIn_t              coreIn,
    input  wire coreOut_t             coreOut,
    // power management
    input  wire logic                 haltMode,
    input  wire logic                 stopMode,
    input  wire logic                 wdtTimeout,
    input  wire logic [ROW_WIDTH-1:0] rowPins,
    input  wire logic                 hostData,
    input  wire logic                 haltWake,
    input  wire logic                 stopWake
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // a request waits one cycle, then the answer stands for exactly one cycle
    sequence busAsk;
        (read || write) && waitrequest;
    endsequence
    sequence busDone;
        !waitrequest ##1 waitrequest;
    endsequence
    // a falling row or host sample taken while stopped
    sequence wakeEdge;
        stopMode && ((|($past(rowPins) & ~rowPins)) || ($past(hostData) && !hostData));
    endsequence

    a_bus_one_wait: assert property (busAsk |=> busDone)
        else $error("bus answer not after one wait cycle");
    a_read_lane_only: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
        else $error("read data above lane 0 not zero");
    a_grant_blocks: assert property (coreIn.grant && coreOut.intReq |=> !coreOut.intReq)
        else $error("request still shown after grant");
    a_vector_pair: assert property (coreOut.intReq |->
        coreOut.source < 3'h5 && coreOut.vector == {12'h0, coreOut.source, 1'b0})
        else $error("vector does not match source");
    // software writes and watchdog reach the request one cycle late, so skip both cycles
    a_pending_holds: assert property (coreOut.intReq && !coreIn.grant && !write && !wdtTimeout
        && !$past(write) && !$past(wdtTimeout) |=> coreOut.intReq)
        else $error("request lost before grant");
    a_halt_wake_off: assert property (!haltMode |=> !haltWake)
        else $error("halt wake outside halt");
    a_wdt_clears: assert property (wdtTimeout |-> ##2 (!coreOut.intReq && !haltWake))
        else $error("watchdog left a request");
    a_stop_wake: assert property (wakeEdge |-> ##[1:2] stopWake)
        else $error("no wake pulse after falling edge in stop");
    a_no_idle_wake: assert property (!stopMode [*3] |=> !stopWake)
        else $error("wake pulse while not stopped");
endmodule : vectored_irq_props

bind vectored_irq_with_timer vectored_irq_props u_vectored_irq_props (.ref_clk, .sys_rst,
    .read, .write, .readdata, .waitrequest, .coreIn, .coreOut, .haltMode, .stopMode,
    .wdtTimeout, .rowPins, .hostData, .haltWake, .stopWake);

`default_nettype wire

// [testbench/core_model.sv]
`timescale 1ns/10ps
`default_nettype none

module core_model
    import vectored_irq_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // core link
    input  wire coreOut_t   coreOut,
    output coreIn_t         coreIn,
    // bench control
    input  wire logic       enable,
    input  wire logic [3:0] grantDelay
);
    logic [3:0] waitCnt_q;
    logic [2:0] serviceCnt_q;

    // grant after a set wait, then return; a slow grant checks that requests hold
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            coreIn <= '0;
            waitCnt_q <= 4'h0;
            serviceCnt_q <= 3'h0;
        end else if (serviceCnt_q != 3'h0) begin
            serviceCnt_q <= serviceCnt_q - 3'h1;
            coreIn <= '{grant: 1'b0, iret: (serviceCnt_q == 3'h1)};
        end else if (enable && coreOut.intReq) begin
            if (waitCnt_q == grantDelay) begin
                coreIn <= '{grant: 1'b1, iret: 1'b0};
                serviceCnt_q <= 3'h4;
                waitCnt_q <= 4'h0;
            end else begin
                coreIn <= '0;
                waitCnt_q <= waitCnt_q + 4'h1;
            end
        end else begin
            coreIn <= '0;
            waitCnt_q <= 4'h0;
        end
    end
endmodule : core_model

`default_nettype wire

// [testbench/vectored_irq_with_timer_test.sv]
`timescale 1ns/10ps
`default_nettype none

module vectored_irq_with_timer_test
    import vectored_irq_pkg::*;
;
    logic        ref_clk, sys_rst, read, write, haltMode, stopMode, wdtTimeout;
    logic        hostData, waitrequest, haltWake, stopWake, irq, coreEn;
    logic [9:0]  address;
    logic [31:0] writedata, readdata;
    logic [3:0]  byteenable, requestInputPins, grantDelay;
    logic [7:0]  rowPins;
    coreIn_t     coreIn;
    coreOut_t    coreOut;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;

    vectored_irq_with_timer u_vectored_irq_with_timer (.ref_clk, .sys_rst, .address, .read,
        .write, .writedata, .byteenable, .readdata, .waitrequest, .requestInputPins, .coreIn,
        .coreOut, .haltMode, .stopMode, .wdtTimeout, .rowPins, .hostData, .haltWake,
        .stopWake, .irq);
    core_model u_core_model (.ref_clk, .sys_rst, .coreOut, .coreIn, .enable(coreEn),
        .grantDelay);

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one avalon access; the request stands until waitrequest is sampled low
    task xfer(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge ref_clk);
        address <= {idx, 2'b00};
        writedata <= {24'h0, d};
        write <= w;
        read <= !w;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        q = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
        if (n >= 20) n_errors++;
    endtask : xfer

    task wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, idx, d, q);
    endtask : wr

    task rdChk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        xfer(1'b0, idx, 8'h00, q);
        check(what, q, exp);
    endtask : rdChk

    task waitGrant;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (coreIn.grant !== 1'b1 && n < 50);
        if (n >= 50) n_errors++;
    endtask : waitGrant

    // pulls the chosen pins low for three cycles
    task trigger(input logic [3:0] m);
        requestInputPins <= ~m;
        repeat (3) @(posedge ref_clk);
        requestInputPins <= 4'hF;
        repeat (2) @(posedge ref_clk);
    endtask : trigger

    task regScenario;
        rdChk("mask reset", IDX_MASK, RST_MASK);
        rdChk("cold start", IDX_PENDING, 8'h00);
        wr(IDX_MASK, 8'h9F);
        byteenable <= 4'hE;
        wr(IDX_MASK, 8'h11);
        byteenable <= 4'hF;
        rdChk("mask lane", IDX_MASK, 8'h9F);
        wr(IDX_MASK, 8'h00);
        wr(IDX_PRIORITY, 8'h03);
        rdChk("priority wo", IDX_PRIORITY, 8'h00);
        wr(IDX_PRESCALE, 8'h0D);
        rdChk("prescale wo", IDX_PRESCALE, 8'h00);
        wr(8'h10, 8'hAA);
        rdChk("unmapped", 8'h10, 8'h00);
    endtask : regScenario

    task pollScenario;
        trigger(4'h4);
        rdChk("pin unused", IDX_PENDING, 8'h00);
        wr(IDX_PIN_CONFIG, 8'h0F);
        wr(IDX_MASK, 8'h04);
        trigger(4'h4);
        check("global off", coreOut.intReq, 1'b0);
        rdChk("polled", IDX_PENDING, 8'h04);
        wr(IDX_MASK, 8'h84);
        repeat (3) @(posedge ref_clk);
        check("global on", coreOut.intReq, 1'b1);
        wr(IDX_MASK, 8'h00);
        wr(IDX_PENDING, 8'h00);
        rdChk("sw clear", IDX_PENDING, 8'h00);
    endtask : pollScenario

    // all four pins wait; the favoured one goes first, then upward with wrap
    task prioScenario;
        for (int p = 0; p < 4; p++) begin
            trigger(4'hF);
            wr(IDX_PRIORITY, 8'(p));
            grantDelay <= 4'(p);
            coreEn <= 1'b1;
            wr(IDX_MASK, 8'h8F);
            for (int k = 0; k < 4; k++) begin
                waitGrant;
                check("source", coreOut.source, (p + k) % 4);
                check("vector", coreOut.vector, 2 * ((p + k) % 4));
            end
            rdChk("drained", IDX_PENDING, 8'h00);
            coreEn <= 1'b0;
            wr(IDX_MASK, 8'h00);
        end
    endtask : prioScenario

    task timerPoll(input logic [7:0] pre, input logic [7:0] cnt, input int per);
        wr(IDX_PRESCALE, pre);
        wr(IDX_TIMER_COUNT, cnt);
        wr(IDX_TIMER_MODE, 8'h03);
        repeat (per - 8) @(posedge ref_clk);
        rdChk("timer early", IDX_PENDING, 8'h00);
        repeat (12) @(posedge ref_clk);
        rdChk("timer end", IDX_PENDING, 8'h10);
        wr(IDX_PENDING, 8'h00);
    endtask : timerPoll

    task timerScenario;
        int t0;
        logic [7:0] q1;
        logic [7:0] q2;
        timerPoll(8'h04, 8'h00, 256);
        timerPoll(8'h00, 8'h01, 64);
        rdChk("single pass", IDX_TIMER_COUNT, 8'h00);
        wr(IDX_PRESCALE, 8'h0D);
        wr(IDX_TIMER_COUNT, 8'h04);
        wr(IDX_MASK, 8'h90);
        grantDelay <= 4'h0;
        coreEn <= 1'b1;
        wr(IDX_TIMER_MODE, 8'h03);
        waitGrant;
        check("timer source", coreOut.source, 3'h4);
        t0 = cyc;
        waitGrant;
        check("period", cyc - t0, 12);
        wr(IDX_TIMER_MODE, 8'h00);
        coreEn <= 1'b0;
        rdChk("mode stopped", IDX_TIMER_MODE, 8'h00);
        xfer(1'b0, IDX_TIMER_COUNT, 8'h00, q1);
        repeat (30) @(posedge ref_clk);
        rdChk("held count", IDX_TIMER_COUNT, q1);
        wr(IDX_TIMER_MODE, 8'h02);
        repeat (30) @(posedge ref_clk);
        xfer(1'b0, IDX_TIMER_COUNT, 8'h00, q2);
        check("resumed", q2 != q1, 1'b1);
        wr(IDX_TIMER_MODE, 8'h01);
        rdChk("restart", IDX_TIMER_COUNT, 8'h04);
        wr(IDX_MASK, 8'h00);
        wr(IDX_PENDING, 8'h00);
    endtask : timerScenario

    task stopTry(input logic useHost);
        int n;
        stopMode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        if (useHost) hostData <= 1'b0;
        else rowPins <= 8'hF7;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (stopWake !== 1'b1 && n < 10);
        check("stop wake", n < 10, 1'b1);
        stopMode <= 1'b0;
        hostData <= 1'b1;
        rowPins <= 8'hFF;
        rdChk("warm", IDX_PENDING, 8'h40);
        rdChk("warm cleared", IDX_PENDING, 8'h00);
    endtask : stopTry

    task wakeScenario;
        wr(IDX_EVT_STATUS, 8'h0F);
        wr(IDX_EVT_MASK, 8'h04);
        wdtTimeout <= 1'b1;
        @(posedge ref_clk);
        wdtTimeout <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check("irq raised", irq, 1'b1);
        wr(IDX_EVT_MASK, 8'h00);
        repeat (2) @(posedge ref_clk);
        check("irq masked", irq, 1'b0);
        wr(IDX_EVT_MASK, 8'h04);
        wr(IDX_EVT_STATUS, 8'h04);
        repeat (2) @(posedge ref_clk);
        check("irq cleared", irq, 1'b0);
        rdChk("hot set", IDX_PENDING, 8'h80);
        rdChk("hot cleared", IDX_PENDING, 8'h00);
        stopTry(1'b0);
        stopTry(1'b1);
        // watchdog dropped the pin setup, so halt needs it again
        wr(IDX_PIN_CONFIG, 8'h0F);
        wr(IDX_MASK, 8'h01);
        haltMode <= 1'b1;
        trigger(4'h1);
        check("halt wake", haltWake, 1'b1);
        haltMode <= 1'b0;
    endtask : wakeScenario

    task finish_test;
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    // free running clock and a cycle count for period checks
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;

    // the whole run needs about a thousand cycles; a hang is cut off well after
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        finish_test;
    end

    initial begin
        {read, write, haltMode, stopMode, wdtTimeout, coreEn} = '0;
        {address, writedata, grantDelay} = '0;
        byteenable = 4'hF;
        requestInputPins = 4'hF;
        rowPins = 8'hFF;
        hostData = 1'b1;
        sys_rst = 1'b1;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        regScenario;
        pollScenario;
        prioScenario;
        timerScenario;
        wakeScenario;
        finish_test;
    end
endmodule : vectored_irq_with_timer_test

`default_nettype wire
